// ### sep_cfg.svh
`ifndef SEP_CFG_SVH
`define SEP_CFG_SVH

// Instruction codes
`define SEP_OP_SET_LATCH   8'h06
`define SEP_OP_CLR_LATCH   8'h04
`define SEP_OP_READ_STATE  8'h05
`define SEP_OP_STORE_STATE 8'h01
`define SEP_OP_READ        8'h03
`define SEP_OP_WRITE       8'h02

// Array geometry
`define SEP_ADDR_W   13
`define SEP_PAGE_W   5
`define SEP_ERASED   8'hFF

// Frame counts
`define SEP_BIT_LAST  3'h7
`define SEP_ADDR_LAST 4'hF

// Status layout and delivery value
`define SEP_SR_BUSY_BIT  0
`define SEP_SR_LATCH_BIT 1
`define SEP_SR_NV_LO     2
`define SEP_SR_NV_HI     7
`define SEP_SR_DELIVERY  6'h00

// Self-timed write cycle
`define SEP_TW_MS      10
`define SEP_CLK_KHZ    25000
`define SEP_WRITE_CYC  (`SEP_TW_MS * `SEP_CLK_KHZ)

`endif

// ### sep_pkg.sv
`default_nettype none
package sep_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_RD_DATA,
    ST_WR_DATA,
    ST_SR_RD,
    ST_SR_WR,
    ST_WAIT
  } sep_state_e;
endpackage
`default_nettype wire

// ### sep_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "sep_cfg.svh"

// Functional notes
// - Read data bits are driven on serial output at falling clock edges.
// - Address advances by one after each byte shifted out.
// - Address wraps from top of array to zero during reads.
// - Deselect ends a read at any bit position.
// - Read attempted during write cycle is refused like a deselect.
// - Set-latch sets the latch unless a write cycle is running, then device waits for deselect.
// - Deselect not right after a data byte cancels the write.
// - Self-timed write starts when chip select rises after framed write.
// - Busy flag is one during write cycle; status reads still work.
// - Latch clears when the write cycle ends.
// - Up to 32 bytes within one page per write cycle, any start.
// - Page offset wraps to page start and overwrites earlier data.
// - After reset: idle, deselected, latch clear, nonvolatile bits kept.
// - Clock and select transitions invalid for the state are ignored.
// - Writes start only if select rises after a multiple of 8 bits.
// - Array access during programming ignored; programming continues.
// - After set, clear or status read, wait for deselect.
// - Delivery state: array all FFh, status all zero.
// - Opcodes 06, 04, 05, 01, 03, 02 as listed.
// - Instruction and 16 address bits sampled MSB first on rising clock.
// - Busy bit reads 1 while writing; latch bit mirrors the latch.
module sep_core #(
  parameter int          ADDR_W       = `SEP_ADDR_W,
  parameter int          PAGE_W       = `SEP_PAGE_W,
  parameter int unsigned WRITE_CYCLES = `SEP_WRITE_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Serial bus pins
  input  wire logic sel_n_i,
  input  wire logic sclk_i,
  input  wire logic sdi_i,
  output var  logic sdo_o,
  output var  logic sdo_oe_o,
  // Status flags
  output var  logic write_busy_flag_o,
  output var  logic write_latch_flag_o
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam int PAGE  = 1 << PAGE_W;
  localparam int TMR_W = $clog2(WRITE_CYCLES + 1);

  sep_pkg::sep_state_e state_q;

  logic              sel_s1_q, sel_s2_q, sel_s3_q;
  logic              sck_s1_q, sck_s2_q, sck_s3_q;
  logic              sdi_s1_q, sdi_s2_q;
  logic [2:0]        bitcnt_q;
  logic [7:0]        sh_q;
  logic [3:0]        acnt_q;
  logic [ADDR_W-1:0] addr_q;
  logic              is_wr_q;
  logic              got_q;
  logic              wel_q;
  logic              busy_q;
  logic              sr_job_q;
  logic [7:0]        sr_buf_q;
  logic [TMR_W-1:0]  tmr_q;
  logic [PAGE_W-1:0] cidx_q;
  logic              commit_q;
  logic [PAGE_W-1:0] pofs_q;
  logic [PAGE-1:0]   mask_q;
  logic [7:0]        obuf_q [PAGE];
  logic [2:0]        obit_q;
  logic [7:0]        osh_q;
  // erased array and zero status at delivery
  logic [7:0]        mem_q [DEPTH] = '{default: `SEP_ERASED};
  logic [5:0]        nv_q = `SEP_SR_DELIVERY;

  logic              sel_fall, sel_rise, sck_rise, sck_fall;
  logic [7:0]        byte_in;
  logic              byte_done;
  logic              frame_ok, start_w, done_p;
  logic              set_p, clr_p;
  logic [7:0]        status_w;
  logic [7:0]        src_w;
  logic [ADDR_W-1:0] addr_inc;

  // Pins cross in through two flops; third flop only for edges
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sel_s3_q <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
    end
    else
    begin
      sel_s1_q <= sel_n_i;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      sck_s1_q <= sclk_i;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      sdi_s1_q <= sdi_i;
      sdi_s2_q <= sdi_s1_q;
    end
  end

  // clock edges count only while selected
  assign sel_fall  = sel_s3_q & ~sel_s2_q;
  assign sel_rise  = ~sel_s3_q & sel_s2_q;
  assign sck_rise  = ~sck_s3_q & sck_s2_q & ~sel_s2_q;
  assign sck_fall  = sck_s3_q & ~sck_s2_q & ~sel_s2_q;
  assign byte_in   = {sh_q[6:0], sdi_s2_q};
  assign byte_done = sck_rise && (bitcnt_q == `SEP_BIT_LAST);
  assign addr_inc  = addr_q + 1'b1;

  // status layout, nonvolatile bits on top
  assign status_w = {nv_q, wel_q, busy_q};
  assign src_w    = (state_q == sep_pkg::ST_SR_RD) ? status_w
                                                  : mem_q[addr_q];

  // only whole bytes with a data byte in hand
  assign frame_ok = got_q && (bitcnt_q == 3'h0) &&
                    ((state_q == sep_pkg::ST_WR_DATA) ||
                     (state_q == sep_pkg::ST_SR_WR));
  assign start_w = sel_rise && frame_ok && !busy_q;
  assign done_p  = busy_q && (tmr_q == TMR_W'(WRITE_CYCLES - 1));

  assign set_p = byte_done && (state_q == sep_pkg::ST_CMD) &&
                 (byte_in == `SEP_OP_SET_LATCH) && !busy_q;
  assign clr_p = byte_done && (state_q == sep_pkg::ST_CMD) &&
                 (byte_in == `SEP_OP_CLR_LATCH) && !busy_q;

  // Protocol sequencer
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      state_q  <= sep_pkg::ST_IDLE;
      bitcnt_q <= 3'h0;
      sh_q     <= 8'h00;
      acnt_q   <= 4'h0;
      addr_q   <= '0;
      is_wr_q  <= 1'b0;
      got_q    <= 1'b0;
    end
    else if (sel_s2_q)
    begin
      state_q  <= sep_pkg::ST_IDLE;
      bitcnt_q <= 3'h0;
    end
    else if (sel_fall)
    begin
      state_q  <= sep_pkg::ST_CMD;
      bitcnt_q <= 3'h0;
      acnt_q   <= 4'h0;
      got_q    <= 1'b0;
    end
    // sample MSB first on rising clock
    else if (sck_rise)
    begin
      bitcnt_q <= bitcnt_q + 3'h1;
      sh_q     <= byte_in;
      unique case (state_q)
        sep_pkg::ST_CMD:
          if (byte_done)
          begin
            case (byte_in)
              `SEP_OP_READ_STATE:
                state_q <= sep_pkg::ST_SR_RD;
              `SEP_OP_STORE_STATE:
                state_q <= (wel_q && !busy_q) ? sep_pkg::ST_SR_WR
                                              : sep_pkg::ST_WAIT;
              `SEP_OP_READ:
              begin
                state_q <= busy_q ? sep_pkg::ST_WAIT
                                  : sep_pkg::ST_ADDR;
                is_wr_q <= 1'b0;
              end
              `SEP_OP_WRITE:
              begin
                state_q <= (wel_q && !busy_q) ? sep_pkg::ST_ADDR
                                              : sep_pkg::ST_WAIT;
                is_wr_q <= 1'b1;
              end
              // latch ops and unknown codes wait
              default:
                state_q <= sep_pkg::ST_WAIT;
            endcase
          end
        sep_pkg::ST_ADDR:
        begin
          addr_q <= {addr_q[ADDR_W-2:0], sdi_s2_q};
          acnt_q <= acnt_q + 4'h1;
          if (acnt_q == `SEP_ADDR_LAST)
            state_q <= is_wr_q ? sep_pkg::ST_WR_DATA
                               : sep_pkg::ST_RD_DATA;
        end
        sep_pkg::ST_WR_DATA:
          if (byte_done)
            got_q <= 1'b1;
        sep_pkg::ST_SR_WR:
          // Extra bits past the status byte cancel it
          if (got_q)
            state_q <= sep_pkg::ST_WAIT;
          else if (byte_done)
            got_q <= 1'b1;
        sep_pkg::ST_SR_RD:
          // master has sampled all 8 bits
          if (byte_done)
            state_q <= sep_pkg::ST_WAIT;
        sep_pkg::ST_IDLE, sep_pkg::ST_RD_DATA, sep_pkg::ST_WAIT:
          ;
      endcase
    end
    else if (sck_fall && (state_q == sep_pkg::ST_RD_DATA) &&
             (obit_q == `SEP_BIT_LAST))
      // advance after byte out; natural wrap
      addr_q <= addr_inc;
  end

  // Serial output shifter
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i || sel_s2_q)
    begin
      sdo_o    <= 1'b0;
      sdo_oe_o <= 1'b0;
      obit_q   <= 3'h0;
      osh_q    <= 8'h00;
    end
    else if (sck_fall && ((state_q == sep_pkg::ST_RD_DATA) ||
                          (state_q == sep_pkg::ST_SR_RD)))
    begin
      sdo_oe_o <= 1'b1;
      obit_q   <= obit_q + 3'h1;
      if (obit_q == 3'h0)
      begin
        sdo_o <= src_w[7];
        osh_q <= {src_w[6:0], 1'b0};
      end
      else
      begin
        sdo_o <= osh_q[7];
        osh_q <= {osh_q[6:0], 1'b0};
      end
    end
    else if ((state_q != sep_pkg::ST_RD_DATA) &&
             (state_q != sep_pkg::ST_SR_RD))
      sdo_oe_o <= 1'b0;
  end

  // Page buffer fill
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      pofs_q <= '0;
      mask_q <= '0;
    end
    else if (sck_rise && (state_q == sep_pkg::ST_ADDR) &&
             (acnt_q == `SEP_ADDR_LAST))
    begin
      pofs_q <= {addr_q[PAGE_W-2:0], sdi_s2_q};
      mask_q <= '0;
    end
    else if (byte_done && (state_q == sep_pkg::ST_WR_DATA))
    begin
      obuf_q[pofs_q] <= byte_in;
      mask_q[pofs_q] <= 1'b1;
      pofs_q <= pofs_q + 1'b1;
    end
  end

  // Self-timed write cycle
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      busy_q   <= 1'b0;
      sr_job_q <= 1'b0;
      sr_buf_q <= 8'h00;
      tmr_q    <= '0;
      cidx_q   <= '0;
      commit_q <= 1'b0;
    end
    // a misframed deselect never gets here
    else if (start_w)
    begin
      busy_q   <= 1'b1;
      sr_job_q <= (state_q == sep_pkg::ST_SR_WR);
      sr_buf_q <= sh_q;
      tmr_q    <= '0;
      cidx_q   <= '0;
      commit_q <= (state_q == sep_pkg::ST_WR_DATA);
    end
    // busy stands until the cycle ends
    else if (busy_q)
    begin
      tmr_q <= tmr_q + 1'b1;
      if (done_p)
        busy_q <= 1'b0;
      if (commit_q)
      begin
        cidx_q <= cidx_q + 1'b1;
        if (cidx_q == PAGE_W'(PAGE - 1))
          commit_q <= 1'b0;
      end
    end
  end

  // Nonvolatile storage, never reset; initial values are delivery state
  always_ff @(posedge clk_i)
  begin
    if (busy_q && commit_q && mask_q[cidx_q])
      mem_q[{addr_q[ADDR_W-1:PAGE_W], cidx_q}] <= obuf_q[cidx_q];
    // Old protect bits stay visible until the cycle ends
    if (done_p && sr_job_q)
      nv_q <= sr_buf_q[`SEP_SR_NV_HI:`SEP_SR_NV_LO];
  end

  // Write enable latch
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      wel_q <= 1'b0;
    // cleared at end of write cycle
    else if (done_p)
      wel_q <= 1'b0;
    else if (set_p)
      wel_q <= 1'b1;
    else if (clr_p)
      wel_q <= 1'b0;
  end

  assign write_busy_flag_o  = busy_q;
  assign write_latch_flag_o = wel_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_frame_end;
    sel_rise && frame_ok && !busy_q;
  endsequence

  property p_start;
    s_frame_end |=> busy_q && (tmr_q == '0);
  endproperty
  a_start: assert property (p_start)
    else $error("write cycle did not start");

  property p_wip_hold;
    s_frame_end |=> busy_q[*8];
  endproperty
  a_wip_hold: assert property (p_wip_hold)
    else $error("busy dropped early");

  property p_cancel;
    sel_rise && (state_q == sep_pkg::ST_WR_DATA) &&
      (bitcnt_q != 3'h0) && !busy_q |=> !busy_q;
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("misframed write started");

  property p_latch_clr;
    $fell(busy_q) |-> !wel_q;
  endproperty
  a_latch_clr: assert property (p_latch_clr)
    else $error("latch not cleared at cycle end");

  property p_refuse;
    byte_done && (state_q == sep_pkg::ST_CMD) &&
      (byte_in == `SEP_OP_READ) && busy_q
      |=> (state_q == sep_pkg::ST_WAIT);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("read accepted while busy");

  property p_set;
    set_p |=> wel_q && (state_q == sep_pkg::ST_WAIT);
  endproperty
  a_set: assert property (p_set)
    else $error("set latch failed");

  property p_desel;
    sel_rise |=> (state_q == sep_pkg::ST_IDLE) && !sdo_oe_o;
  endproperty
  a_desel: assert property (p_desel)
    else $error("deselect did not end frame");

  property p_inc;
    sck_fall && (state_q == sep_pkg::ST_RD_DATA) &&
      (obit_q == `SEP_BIT_LAST) |=> (addr_q == $past(addr_inc));
  endproperty
  a_inc: assert property (p_inc)
    else $error("address did not advance");

  property p_top_wrap;
    sck_fall && (state_q == sep_pkg::ST_RD_DATA) &&
      (obit_q == `SEP_BIT_LAST) && (addr_q == '1) |=> (addr_q == '0);
  endproperty
  a_top_wrap: assert property (p_top_wrap)
    else $error("address did not wrap");

  property p_pwrap;
    byte_done && (state_q == sep_pkg::ST_WR_DATA) && (pofs_q == '1)
      |=> (pofs_q == '0);
  endproperty
  a_pwrap: assert property (p_pwrap)
    else $error("page offset did not wrap");

  property p_wip_bit;
    sck_fall && (state_q == sep_pkg::ST_SR_RD) &&
      (obit_q == `SEP_BIT_LAST) && busy_q |=> sdo_o;
  endproperty
  a_wip_bit: assert property (p_wip_bit)
    else $error("busy bit not shown in status");

endmodule
`default_nettype wire

// ### sep_master.sv
`timescale 1ns/1ps
`default_nettype none
module sep_master #(
  parameter int HALF = 6
) (
  // Clock
  input  wire logic clk_i,
  // Serial bus pins
  output var  logic sel_n_o,
  output var  logic sclk_o,
  output var  logic sdi_o,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i
);
  logic last_q;
  logic oe_seen;

  initial
  begin
    sel_n_o = 1'b1;
    sclk_o  = 1'b0;
    sdi_o   = 1'b0;
    last_q  = 1'b0;
    oe_seen = 1'b0;
  end

  task automatic start_frame();
    @(posedge clk_i);
    sel_n_o <= 1'b0;
    oe_seen = 1'b0;
    repeat (HALF) @(posedge clk_i);
  endtask

  task automatic shift_bit(input logic b, output logic r);
    @(posedge clk_i);
    sdi_o <= b;
    repeat (HALF - 1) @(posedge clk_i);
    // Sample off the edge; released line reads as inverse of last bit
    @(negedge clk_i);
    r = sdo_oe_i ? sdo_i : ~last_q;
    oe_seen = oe_seen | sdo_oe_i;
    last_q = r;
    @(posedge clk_i);
    sclk_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
    sclk_o <= 1'b0;
  endtask

  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      shift_bit(tx[i], r);
      rx[i] = r;
    end
  endtask

  task automatic stop_frame();
    repeat (HALF) @(posedge clk_i);
    sel_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (2 * HALF) @(posedge clk_i);
  endtask

  task automatic header(input logic [7:0] op, input logic [15:0] addr);
    logic [7:0] rx;
    start_frame();
    shift_byte(op, rx);
    shift_byte(addr[15:8], rx);
    shift_byte(addr[7:0], rx);
  endtask

  task automatic op_only(input logic [7:0] op);
    logic [7:0] rx;
    start_frame();
    shift_byte(op, rx);
    stop_frame();
  endtask
endmodule
`default_nettype wire

// ### serial_eeprom_protocol_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sep_cfg.svh"
module serial_eeprom_protocol_test;
  localparam int unsigned WCYC = 1200;
  logic       clk;
  logic       nrst;
  wire        sel_n;
  wire        sclk;
  wire        sdi;
  wire        sdo;
  wire        sdo_oe;
  wire        busy;
  wire        latch;
  int         errors;
  int         compares;
  logic [7:0] rx;
  logic [7:0] rbuf [2];
  logic [7:0] wbuf [3];

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  sep_core #(.WRITE_CYCLES(WCYC)) i_sep_core (
    .clk_i(clk), .nrst_i(nrst), .sel_n_i(sel_n), .sclk_i(sclk),
    .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .write_busy_flag_o(busy), .write_latch_flag_o(latch)
  );
  sep_master i_sep_master (
    .clk_i(clk), .sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi),
    .sdo_i(sdo), .sdo_oe_i(sdo_oe)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  task automatic stop_test();
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic rd_state(output logic [7:0] st);
    logic b;
    i_sep_master.start_frame();
    i_sep_master.shift_byte(`SEP_OP_READ_STATE, st);
    i_sep_master.shift_byte(8'h00, st);
    i_sep_master.shift_bit(1'b0, b);
    check({7'h00, sdo_oe}, 8'h00);
    i_sep_master.stop_frame();
  endtask

  task automatic read_bytes(input logic [15:0] addr, input int n);
    i_sep_master.header(`SEP_OP_READ, addr);
    for (int i = 0; i < n; i++)
    begin
      i_sep_master.shift_byte(8'h00, rx);
      rbuf[i] = rx;
    end
    i_sep_master.stop_frame();
  endtask

  task automatic write_bytes(input logic [15:0] addr, input int n);
    i_sep_master.header(`SEP_OP_WRITE, addr);
    for (int i = 0; i < n; i++)
      i_sep_master.shift_byte(wbuf[i], rx);
    i_sep_master.stop_frame();
  endtask

  // Bounded wait; a stuck busy flag shows up as a mismatch
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < WCYC + 100)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  initial
  begin
    #2_000_000;
    errors++;
    stop_test();
  end

  initial
  begin
    errors = 0;
    compares = 0;
    nrst = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    check({5'h00, sdo_oe, busy, latch}, 8'h00);
    rd_state(rx);
    check(rx, 8'h00);
    read_bytes(16'h0000, 2);
    check(rbuf[0], 8'hFF);
    check(rbuf[1], 8'hFF);
    wbuf[0] = 8'hA5;
    write_bytes(16'h0010, 1);
    check({7'h00, busy}, 8'h00);
    i_sep_master.op_only(`SEP_OP_SET_LATCH);
    check({7'h00, latch}, 8'h01);
    rd_state(rx);
    check(rx, 8'h02);
    wbuf[0] = 8'h3C;
    wbuf[1] = 8'hC3;
    wbuf[2] = 8'h5A;
    // Three bytes from offset 30 cross the page end
    write_bytes(16'h1FFE, 3);
    check({7'h00, busy}, 8'h01);
    rd_state(rx);
    check(rx, 8'h03);
    read_bytes(16'h1FFE, 1);
    check({7'h00, i_sep_master.oe_seen}, 8'h00);
    i_sep_master.op_only(`SEP_OP_CLR_LATCH);
    check({7'h00, latch}, 8'h01);
    wait_idle();
    check({6'h00, busy, latch}, 8'h00);
    read_bytes(16'h1FFF, 2);
    check(rbuf[0], 8'hC3);
    check(rbuf[1], 8'hFF);
    read_bytes(16'h1FE0, 2);
    check(rbuf[0], 8'h5A);
    check(rbuf[1], 8'hFF);
    // One clock too many before deselect
    i_sep_master.op_only(`SEP_OP_SET_LATCH);
    i_sep_master.header(`SEP_OP_WRITE, 16'h0100);
    i_sep_master.shift_byte(8'h5A, rx);
    i_sep_master.shift_bit(1'b1, rx[0]);
    i_sep_master.stop_frame();
    check({7'h00, busy}, 8'h00);
    i_sep_master.op_only(`SEP_OP_CLR_LATCH);
    check({7'h00, latch}, 8'h00);
    read_bytes(16'h0100, 1);
    check(rbuf[0], 8'hFF);
    // Deselect after three data bits
    i_sep_master.header(`SEP_OP_READ, 16'h1FFE);
    i_sep_master.shift_bit(1'b0, rx[0]);
    i_sep_master.shift_bit(1'b0, rx[0]);
    i_sep_master.shift_bit(1'b0, rx[0]);
    i_sep_master.stop_frame();
    check({7'h00, sdo_oe}, 8'h00);
    read_bytes(16'h1FFE, 2);
    check(rbuf[0], 8'h3C);
    check(rbuf[1], 8'hC3);
    i_sep_master.op_only(`SEP_OP_SET_LATCH);
    i_sep_master.start_frame();
    i_sep_master.shift_byte(`SEP_OP_STORE_STATE, rx);
    i_sep_master.shift_byte(8'h0C, rx);
    i_sep_master.stop_frame();
    check({7'h00, busy}, 8'h01);
    wait_idle();
    rd_state(rx);
    check(rx, 8'h0C);
    // Reset in mid-run keeps status bits, drops latch
    i_sep_master.op_only(`SEP_OP_SET_LATCH);
    check({7'h00, latch}, 8'h01);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    check({5'h00, sdo_oe, busy, latch}, 8'h00);
    rd_state(rx);
    check(rx, 8'h0C);
    stop_test();
  end
endmodule
`default_nettype wire
